// *** phy_rx_status_10bt_ops_regs.sv ***
// Receive event status and 10Base-T operations registers of the PHY with their control logic.
// How it works
// R01 - Non-idle start that is not a J then K pair sets the false-carrier flag.
// R02 - Latching-high flags hold until their register is read or reset, unless events recur.
// R03 - An erroneous symbol in a 100Base packet raises the receive error and invalid flag.
// R04 - A halt symbol in a packet is reported by receive error and sets its flag.
// R05 - Two idles in a row inside a packet set the premature-end flag.
// R06 - The four 100Base event flags are not updated in 10Base-T mode.
// R07 - Negotiation-complete shows zero unless negotiation is enabled and finished.
// R08 - Signal detect mirrors the present receive signal in 100Base-TX mode.
// R09 - Jabber bit is a latching-high copy of the transmit jabber detection.
// R10 - Remote-fault bit latches high like its twin in the basic status register.
// R11 - Link-status bit latches low like its twin in the basic status register.
// R12 - Management writes reserved operation bits with defaults, bit four as one.
// R13 - Receive-path jabber sets remote jabber; reading the register or reset clears it.
// R14 - Remote jabber is informational and drives no action on the port.
// R15 - Auto polarity inhibit low corrects reversed receive polarity, high leaves it.
// R16 - Quality test inhibit low runs the collision test after transmissions, high stops it.
// R17 - Link loss inhibit forces the 10Base-T link into the passed state.
// R18 - Reversed receive pair latches the polarity flag while operation continues normally.
// R19 - Jabber inhibit low checks transmit jabber, high skips the check.
// R20 - Squelch inhibit demands valid data then idle before the 10Base-T link passes.
// R21 - The collision test is suppressed in full duplex and repeater modes regardless.
// R22 - Reads return flags before clearing; a same-cycle event stays for the next read.
`timescale 1ns/1ps
module phy_rx_status_10bt_ops_regs #(
	parameter int JABBER_CYCLES = phy_regs_pkg::JABBER_CYCLES
) (
	// Clock and reset.
	input  wire logic        CLK_SYS_IN,
	input  wire logic        RESET_N_IN,
	// Management register port.
	input  wire logic [4:0]  MGMT_ADDR_IN,
	input  wire logic        MGMT_READ_IN,
	input  wire logic        MGMT_WRITE_IN,
	input  wire logic [15:0] MGMT_WDATA_IN,
	output logic      [15:0] MGMT_RDATA_OUT,
	output logic             MGMT_RVALID_OUT,
	// Operating mode from the rest of the PHY.
	input  wire logic        SPEED_100_IN,
	input  wire logic        FULL_DUPLEX_IN,
	input  wire logic        REPEATER_MODE_IN,
	input  wire logic        AN_ENABLE_IN,
	input  wire logic        AN_DONE_IN,
	input  wire logic        REMOTE_FAULT_IN,
	input  wire logic        LINK100_IN,
	// 100Base receive symbols.
	input  wire logic [4:0]  RX_SYMBOL_IN,
	input  wire logic        RX_SYMBOL_VALID_IN,
	output logic             RXER_OUT,
	// Twisted-pair receiver levels, asynchronous.
	input  wire logic        PAIR_SIGNAL_DETECT_IN,
	input  wire logic        PAIR_POLARITY_REVERSED_IN,
	// 10Base-T activity.
	input  wire logic        TX_EN_IN,
	input  wire logic        RX_CARRIER_IN,
	input  wire logic        RX10_VALID_DATA_IN,
	input  wire logic        RX10_IDLE_IN,
	input  wire logic        LINK_PULSE_FAIL_IN,
	// Port controls.
	output logic             LINK_PASS_OUT,
	output logic             JABBER_OUT,
	output logic             SQE_TEST_OUT,
	output logic             POLARITY_CORRECT_OUT
);

	localparam int JW = $clog2(JABBER_CYCLES + 1);
	localparam int SW = $clog2(phy_regs_pkg::SQE_CYCLES + 1);

	generate
		if (JABBER_CYCLES < 2) begin : g_bad_jabber
			$error("JABBER_CYCLES must be at least 2");
		end
	endgenerate

	// Access decode.
	logic        read_status;
	logic        read_ops;
	logic        write_ops;
	assign read_status = MGMT_READ_IN && (MGMT_ADDR_IN == phy_regs_pkg::ADDR_EVENT_STATUS);
	assign read_ops = MGMT_READ_IN && (MGMT_ADDR_IN == phy_regs_pkg::ADDR_TEN_BASE_T_OPS);
	assign write_ops = MGMT_WRITE_IN && (MGMT_ADDR_IN == phy_regs_pkg::ADDR_TEN_BASE_T_OPS);

	// Control bits 13:0 of the operations register, reserved ones kept as written.
	logic [13:0] ops_control;
	always_ff @(posedge CLK_SYS_IN) begin
		if (!RESET_N_IN) begin
			ops_control <= phy_regs_pkg::OPS_CONTROL_RESET;
		end else if (write_ops) begin
			ops_control <= MGMT_WDATA_IN[13:0]; // R12
		end
	end

	logic jabber_inhibit;
	logic auto_pol_inhibit;
	logic sqe_inhibit;
	logic link_loss_inhibit;
	logic squelch_inhibit;
	assign jabber_inhibit = ops_control[phy_regs_pkg::OPS_JABBER_INHIBIT];
	assign auto_pol_inhibit = ops_control[phy_regs_pkg::OPS_AUTO_POLARITY_INHIBIT];
	assign sqe_inhibit = ops_control[phy_regs_pkg::OPS_SQE_TEST_INHIBIT];
	assign link_loss_inhibit = ops_control[phy_regs_pkg::OPS_LINK_LOSS_INHIBIT];
	assign squelch_inhibit = ops_control[phy_regs_pkg::OPS_SQUELCH_INHIBIT];

	// Receiver pin levels.
	logic [1:0] pin_level;
	logic       signal_present;
	logic       pol_reversed;
	pin_sync #(
		.WIDTH(2)
	) u_pin_sync (
		.clk_in    (CLK_SYS_IN),
		.reset_n_in(RESET_N_IN),
		.async_in  ({PAIR_POLARITY_REVERSED_IN, PAIR_SIGNAL_DETECT_IN}),
		.level_out (pin_level)
	);
	assign signal_present = pin_level[0];
	assign pol_reversed = pin_level[1];

	// 100Base receive symbol tracking.
	phy_regs_pkg::sym_state_t sym_state;
	phy_regs_pkg::sym_state_t next_sym_state;
	logic prev_idle;
	logic next_prev_idle;
	logic ev_false_carrier;
	logic ev_invalid;
	logic ev_halt;
	logic ev_premature;

	function automatic logic is_data_code(input logic [4:0] c);
		case (c)
			5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
			5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d: is_data_code = 1'b1;
			default: is_data_code = 1'b0;
		endcase
	endfunction

	always_comb begin
		next_sym_state = sym_state;
		next_prev_idle = prev_idle;
		ev_false_carrier = 1'b0;
		ev_invalid = 1'b0;
		ev_halt = 1'b0;
		ev_premature = 1'b0;
		if (RX_SYMBOL_VALID_IN && SPEED_100_IN) begin // R06
			case (sym_state)
				phy_regs_pkg::SYM_IDLE: begin
					if (RX_SYMBOL_IN == phy_regs_pkg::CODE_J) begin
						next_sym_state = phy_regs_pkg::SYM_GOT_J;
					end else if (RX_SYMBOL_IN != phy_regs_pkg::CODE_IDLE) begin
						ev_false_carrier = 1'b1; // R01
					end
				end
				phy_regs_pkg::SYM_GOT_J: begin
					next_prev_idle = 1'b0;
					if (RX_SYMBOL_IN == phy_regs_pkg::CODE_K) begin
						next_sym_state = phy_regs_pkg::SYM_PACKET;
					end else begin
						ev_false_carrier = 1'b1; // R01
						next_sym_state = phy_regs_pkg::SYM_IDLE;
					end
				end
				phy_regs_pkg::SYM_PACKET: begin
					next_prev_idle = (RX_SYMBOL_IN == phy_regs_pkg::CODE_IDLE);
					if (RX_SYMBOL_IN == phy_regs_pkg::CODE_IDLE) begin
						if (prev_idle) begin
							ev_premature = 1'b1; // R05
							next_sym_state = phy_regs_pkg::SYM_IDLE;
						end
					end else if (RX_SYMBOL_IN == phy_regs_pkg::CODE_T) begin
						next_sym_state = phy_regs_pkg::SYM_END;
					end else if (RX_SYMBOL_IN == phy_regs_pkg::CODE_HALT) begin
						ev_halt = 1'b1; // R04
					end else if (!is_data_code(RX_SYMBOL_IN)) begin
						ev_invalid = 1'b1; // R03
					end
				end
				phy_regs_pkg::SYM_END: begin
					if (RX_SYMBOL_IN != phy_regs_pkg::CODE_R) begin
						ev_invalid = 1'b1; // R03
					end
					next_sym_state = phy_regs_pkg::SYM_IDLE;
				end
				default: begin
					next_sym_state = phy_regs_pkg::SYM_IDLE;
				end
			endcase
		end else if (!SPEED_100_IN) begin
			next_sym_state = phy_regs_pkg::SYM_IDLE;
			next_prev_idle = 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (!RESET_N_IN) begin
			sym_state <= phy_regs_pkg::SYM_IDLE;
			prev_idle <= 1'b0;
		end else begin
			sym_state <= next_sym_state;
			prev_idle <= next_prev_idle;
		end
	end

	// Receive error toward the MAC or repeater is registered, one cycle after the offending symbol.
	always_ff @(posedge CLK_SYS_IN) begin
		if (!RESET_N_IN) begin
			RXER_OUT <= 1'b0;
		end else begin
			RXER_OUT <= ev_invalid || ev_halt; // R03 R04
		end
	end

	// Transmit and receive jabber timers.
	logic [JW-1:0] tx_jab_count;
	logic [JW-1:0] rx_jab_count;
	logic          ev_tx_jabber;
	logic          ev_rx_jabber;
	assign ev_tx_jabber = !SPEED_100_IN && TX_EN_IN && !jabber_inhibit
		&& (tx_jab_count == JW'(JABBER_CYCLES - 1)); // R19
	assign ev_rx_jabber = !SPEED_100_IN && RX_CARRIER_IN
		&& (rx_jab_count == JW'(JABBER_CYCLES - 1)); // R13

	always_ff @(posedge CLK_SYS_IN) begin
		if (!RESET_N_IN) begin
			tx_jab_count <= '0;
			JABBER_OUT <= 1'b0;
		end else if (SPEED_100_IN || !TX_EN_IN || jabber_inhibit) begin
			tx_jab_count <= '0;
			JABBER_OUT <= 1'b0;
		end else if (ev_tx_jabber) begin
			JABBER_OUT <= 1'b1; // R19
		end else if (!JABBER_OUT) begin
			tx_jab_count <= tx_jab_count + JW'(1);
		end
	end

	// The receive jabber only feeds its flag; the port keeps running.
	logic rx_jabbering;
	always_ff @(posedge CLK_SYS_IN) begin
		if (!RESET_N_IN) begin
			rx_jab_count <= '0;
			rx_jabbering <= 1'b0;
		end else if (SPEED_100_IN || !RX_CARRIER_IN) begin
			rx_jab_count <= '0;
			rx_jabbering <= 1'b0;
		end else if (ev_rx_jabber) begin
			rx_jabbering <= 1'b1; // R14
		end else if (!rx_jabbering) begin
			rx_jab_count <= rx_jab_count + JW'(1);
		end
	end

	// Latching-high flags of the two registers.
	logic [5:0] status_flags;
	logic [1:0] ops_flags;
	logic       remote_fault_d;
	logic       pol_reversed_d;
	always_ff @(posedge CLK_SYS_IN) begin
		if (!RESET_N_IN) begin
			remote_fault_d <= 1'b0;
			pol_reversed_d <= 1'b0;
		end else begin
			remote_fault_d <= REMOTE_FAULT_IN;
			pol_reversed_d <= pol_reversed;
		end
	end

	latch_high_flags #(
		.WIDTH(6)
	) u_status_flags (
		.clk_in    (CLK_SYS_IN),
		.reset_n_in(RESET_N_IN),
		.set_in    ({ev_false_carrier, ev_invalid, ev_halt, ev_premature,
			ev_tx_jabber, REMOTE_FAULT_IN && !remote_fault_d}), // R09 R10
		.clear_in  (read_status),
		.flag_out  (status_flags)
	);

	latch_high_flags #(
		.WIDTH(2)
	) u_ops_flags (
		.clk_in    (CLK_SYS_IN),
		.reset_n_in(RESET_N_IN),
		.set_in    ({ev_rx_jabber, pol_reversed && !pol_reversed_d}), // R13 R18
		.clear_in  (read_ops),
		.flag_out  (ops_flags)
	);

	// 10Base-T link integrity.
	logic link10;
	logic seen_data;
	always_ff @(posedge CLK_SYS_IN) begin
		if (!RESET_N_IN) begin
			link10 <= 1'b0;
			seen_data <= 1'b0;
		end else if (link_loss_inhibit) begin
			link10 <= 1'b1; // R17
			seen_data <= 1'b0;
		end else if (LINK_PULSE_FAIL_IN) begin
			link10 <= 1'b0;
			seen_data <= 1'b0;
		end else if (!link10) begin
			if (!squelch_inhibit && RX10_VALID_DATA_IN) begin
				link10 <= 1'b1; // R20
			end else if (squelch_inhibit && seen_data && RX10_IDLE_IN) begin
				link10 <= 1'b1; // R20
			end
			if (RX10_VALID_DATA_IN) begin
				seen_data <= 1'b1;
			end
		end
	end

	logic link_now;
	assign link_now = SPEED_100_IN ? LINK100_IN : link10;

	// Link status latches low: a drop holds zero until read, then follows the link.
	logic link_latched;
	always_ff @(posedge CLK_SYS_IN) begin
		if (!RESET_N_IN) begin
			link_latched <= 1'b0;
		end else if (!link_now) begin
			link_latched <= 1'b0; // R11 R22
		end else if (read_status) begin
			link_latched <= 1'b1; // R11
		end
	end

	// Collision pulse of the quality test after each transmission.
	logic          tx_en_d;
	logic [SW-1:0] sqe_count;
	always_ff @(posedge CLK_SYS_IN) begin
		if (!RESET_N_IN) begin
			tx_en_d <= 1'b0;
			sqe_count <= '0;
			SQE_TEST_OUT <= 1'b0;
		end else begin
			tx_en_d <= TX_EN_IN;
			if (tx_en_d && !TX_EN_IN && !SPEED_100_IN && !sqe_inhibit // R16
				&& !FULL_DUPLEX_IN && !REPEATER_MODE_IN) begin // R21
				sqe_count <= SW'(phy_regs_pkg::SQE_CYCLES);
				SQE_TEST_OUT <= 1'b1;
			end else if (sqe_count != '0) begin
				sqe_count <= sqe_count - SW'(1);
				SQE_TEST_OUT <= (sqe_count != SW'(1));
			end
		end
	end

	// Port control outputs.
	always_ff @(posedge CLK_SYS_IN) begin
		if (!RESET_N_IN) begin
			LINK_PASS_OUT <= 1'b0;
			POLARITY_CORRECT_OUT <= 1'b0;
		end else begin
			LINK_PASS_OUT <= link_now;
			POLARITY_CORRECT_OUT <= pol_reversed && !auto_pol_inhibit; // R15
		end
	end

	// Read data: values before any clearing read takes effect.
	logic [15:0] status_word;
	always_comb begin
		status_word = 16'h0000;
		status_word[phy_regs_pkg::EV_FALSE_CARRIER] = status_flags[5];
		status_word[phy_regs_pkg::EV_INVALID_SYMBOL] = status_flags[4];
		status_word[phy_regs_pkg::EV_HALT_SYMBOL] = status_flags[3];
		status_word[phy_regs_pkg::EV_PREMATURE_END] = status_flags[2];
		status_word[phy_regs_pkg::EV_AN_COMPLETE] = AN_ENABLE_IN && AN_DONE_IN; // R07
		status_word[phy_regs_pkg::EV_SIGNAL_DETECT] = SPEED_100_IN && signal_present; // R08
		status_word[phy_regs_pkg::EV_JABBER] = status_flags[1]; // R09
		status_word[phy_regs_pkg::EV_REMOTE_FAULT] = status_flags[0]; // R10
		status_word[phy_regs_pkg::EV_LINK_STATUS] = link_latched; // R11
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (!RESET_N_IN) begin
			MGMT_RDATA_OUT <= 16'h0000;
			MGMT_RVALID_OUT <= 1'b0;
		end else begin
			MGMT_RVALID_OUT <= MGMT_READ_IN;
			if (read_status) begin
				MGMT_RDATA_OUT <= status_word; // R22
			end else if (read_ops) begin
				MGMT_RDATA_OUT <= {ops_flags, ops_control}; // R13 R22
			end else if (MGMT_READ_IN) begin
				MGMT_RDATA_OUT <= 16'h0000;
			end
		end
	end

endmodule

// *** phy_regs_pkg.sv ***
// Constants shared by the PHY receive status and 10Base-T operations register logic.
package phy_regs_pkg;

	// Clock rate of the management domain.
	localparam int CLK_MHZ = 125;

	// Register addresses on the management port.
	localparam logic [4:0] ADDR_EVENT_STATUS = 5'h11;
	localparam logic [4:0] ADDR_TEN_BASE_T_OPS = 5'h12;

	// Receive event status field positions.
	localparam int EV_FALSE_CARRIER = 8;
	localparam int EV_INVALID_SYMBOL = 7;
	localparam int EV_HALT_SYMBOL = 6;
	localparam int EV_PREMATURE_END = 5;
	localparam int EV_AN_COMPLETE = 4;
	localparam int EV_SIGNAL_DETECT = 3;
	localparam int EV_JABBER = 2;
	localparam int EV_REMOTE_FAULT = 1;
	localparam int EV_LINK_STATUS = 0;

	// 10Base-T operations field positions.
	localparam int OPS_REMOTE_JABBER = 15;
	localparam int OPS_POLARITY_REVERSED = 14;
	localparam int OPS_JABBER_INHIBIT = 5;
	localparam int OPS_RESERVED_ONE = 4;
	localparam int OPS_AUTO_POLARITY_INHIBIT = 3;
	localparam int OPS_SQE_TEST_INHIBIT = 2;
	localparam int OPS_LINK_LOSS_INHIBIT = 1;
	localparam int OPS_SQUELCH_INHIBIT = 0;

	// Writable control bits 13:0 after reset; only the reserved bit 4 is one.
	localparam logic [13:0] OPS_CONTROL_RESET = 14'h0010;

	// 4B/5B code groups of interest.
	localparam logic [4:0] CODE_IDLE = 5'h1f;
	localparam logic [4:0] CODE_J = 5'h18;
	localparam logic [4:0] CODE_K = 5'h11;
	localparam logic [4:0] CODE_T = 5'h0d;
	localparam logic [4:0] CODE_R = 5'h07;
	localparam logic [4:0] CODE_HALT = 5'h04;

	// Jabber limit and the length of the collision pulse of the quality test.
	localparam int JABBER_TIME_US = 20000;
	localparam int JABBER_CYCLES = JABBER_TIME_US * CLK_MHZ;
	localparam int SQE_TIME_NS = 1000;
	localparam int SQE_CYCLES = (SQE_TIME_NS * CLK_MHZ + 999) / 1000;

	// Receive symbol tracker states.
	typedef enum logic [3:0] {
		SYM_IDLE   = 4'b0001,
		SYM_GOT_J  = 4'b0010,
		SYM_PACKET = 4'b0100,
		SYM_END    = 4'b1000
	} sym_state_t;

endpackage

// *** pin_sync.sv ***
// Three-stage synchroniser for asynchronous pin levels with agreement filter.
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset.
	input  wire logic             clk_in,
	input  wire logic             reset_n_in,
	// Asynchronous levels and their filtered copies.
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] level_out
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// A change counts once the second and third stages agree.
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk_in) begin
				if (!reset_n_in) begin
					level_out[i] <= 1'b0;
				end else if (stage2[i] == stage3[i]) begin
					level_out[i] <= stage3[i];
				end
			end
		end
	endgenerate

endmodule

// *** latch_high_flags.sv ***
// Bank of latching-high flags cleared by a register read, with set winning over clear.
`timescale 1ns/1ps
module latch_high_flags #(
	parameter int WIDTH = 1
) (
	// Clock and reset.
	input  wire logic             clk_in,
	input  wire logic             reset_n_in,
	// Event pulses and the clearing read.
	input  wire logic [WIDTH-1:0] set_in,
	input  wire logic             clear_in,
	// Latched flags.
	output logic      [WIDTH-1:0] flag_out
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_flag
			always_ff @(posedge clk_in) begin
				if (!reset_n_in) begin
					flag_out[i] <= 1'b0;
				end else if (set_in[i]) begin
					flag_out[i] <= 1'b1; // R02 R22
				end else if (clear_in) begin
					flag_out[i] <= 1'b0; // R02
				end
			end
		end
	endgenerate

endmodule

// *** phy_regs_checker_sva.sv ***
// Concurrent checks on the ports of the receive status and operations registers.
`timescale 1ns/1ps
module phy_regs_checker #(
	parameter int JABBER_CYCLES = 50
) (
	// Clock, reset and the watched ports.
	input wire logic        CLK_SYS_IN,
	input wire logic        RESET_N_IN,
	input wire logic [4:0]  MGMT_ADDR_IN,
	input wire logic        MGMT_READ_IN,
	input wire logic        MGMT_WRITE_IN,
	input wire logic [15:0] MGMT_WDATA_IN,
	input wire logic [15:0] MGMT_RDATA_OUT,
	input wire logic        MGMT_RVALID_OUT,
	input wire logic        SPEED_100_IN,
	input wire logic        FULL_DUPLEX_IN,
	input wire logic        REPEATER_MODE_IN,
	input wire logic        AN_ENABLE_IN,
	input wire logic        RX_SYMBOL_VALID_IN,
	input wire logic        RXER_OUT,
	input wire logic        TX_EN_IN,
	input wire logic        LINK_PASS_OUT,
	input wire logic        JABBER_OUT,
	input wire logic        SQE_TEST_OUT,
	input wire logic        POLARITY_CORRECT_OUT
);
	logic [13:0] ctrl;
	int          sqe_len;
	int          tx_run;

	// Shadow of the writable control bits, rebuilt from the write strobes.
	always_ff @(posedge CLK_SYS_IN) begin
		if (!RESET_N_IN) begin
			ctrl <= phy_regs_pkg::OPS_CONTROL_RESET;
		end else if (MGMT_WRITE_IN && MGMT_ADDR_IN == phy_regs_pkg::ADDR_TEN_BASE_T_OPS) begin
			ctrl <= MGMT_WDATA_IN[13:0];
		end
	end

	always_ff @(posedge CLK_SYS_IN) begin
		sqe_len <= (!RESET_N_IN || !SQE_TEST_OUT) ? 0 : sqe_len + 1;
		tx_run <= (!RESET_N_IN || !TX_EN_IN) ? 0 : tx_run + 1;
	end

	default clocking @(posedge CLK_SYS_IN); endclocking
	default disable iff (!RESET_N_IN);

	sequence tx_end_s;
		TX_EN_IN ##1 !TX_EN_IN;
	endsequence
	sequence sqe_allowed_s;
		!SPEED_100_IN && !FULL_DUPLEX_IN && !REPEATER_MODE_IN && !ctrl[2] && !JABBER_OUT;
	endsequence
	sequence status_read_s;
		MGMT_READ_IN && MGMT_ADDR_IN == phy_regs_pkg::ADDR_EVENT_STATUS && !AN_ENABLE_IN;
	endsequence

	read_answer_a: assert property (MGMT_READ_IN |=> MGMT_RVALID_OUT)
		else $error("read strobe got no answer");
	no_stray_valid_a: assert property (!MGMT_READ_IN |=> !MGMT_RVALID_OUT)
		else $error("read valid without a read");
	an_disabled_a: assert property (status_read_s |=> !MGMT_RDATA_OUT[4])
		else $error("negotiation complete shown while disabled");
	rxer_cause_a: assert property (RXER_OUT |-> $past(RX_SYMBOL_VALID_IN) && $past(SPEED_100_IN))
		else $error("receive error without a 100Base symbol");
	sqe_start_a: assert property (tx_end_s ##0 sqe_allowed_s |-> ##[1:2] SQE_TEST_OUT)
		else $error("quality test pulse missing");
	sqe_length_a: assert property ($fell(SQE_TEST_OUT) |-> sqe_len == phy_regs_pkg::SQE_CYCLES)
		else $error("quality test pulse length wrong");
	sqe_suppress_a: assert property ($rose(SQE_TEST_OUT) |->
		!$past(FULL_DUPLEX_IN) && !$past(REPEATER_MODE_IN) && !$past(ctrl[2]))
		else $error("quality test pulse while suppressed");
	jabber_time_a: assert property ($rose(JABBER_OUT) |->
		tx_run >= JABBER_CYCLES - 1 && tx_run <= JABBER_CYCLES + 2 && !ctrl[5])
		else $error("jabber raised at the wrong time");
	link_forced_a: assert property (ctrl[1] && !SPEED_100_IN ##1 ctrl[1] && !SPEED_100_IN
		|=> LINK_PASS_OUT)
		else $error("forced link not passed");
	pol_inhibit_a: assert property (ctrl[3] ##1 ctrl[3] |-> !POLARITY_CORRECT_OUT)
		else $error("polarity corrected while inhibited");
endmodule

// *** mgmt_station.sv ***
// Station management model issuing register reads and writes.
`timescale 1ns/1ps
module mgmt_station (
	// Clock.
	input  wire logic        clk_in,
	// Register strobes toward the device.
	output logic      [4:0]  addr_out,
	output logic             read_out,
	output logic             write_out,
	output logic      [15:0] wdata_out
);
	initial begin
		addr_out = 5'h00;
		read_out = 1'b0;
		write_out = 1'b0;
		wdata_out = 16'h0000;
	end

	task automatic rd(input logic [4:0] a);
		@(negedge clk_in);
		addr_out = a;
		read_out = 1'b1;
		@(negedge clk_in);
		read_out = 1'b0;
		addr_out = ~a;
	endtask

	// Reserved bits always carry their defaults, bit 4 one and the rest zero.
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(negedge clk_in);
		addr_out = a;
		wdata_out = {d[15:14], 8'h00, d[5], 1'b1, d[3:0]};
		write_out = 1'b1;
		@(negedge clk_in);
		write_out = 1'b0;
		addr_out = ~a;
		wdata_out = ~wdata_out;
	endtask
endmodule

// *** test_phy_rx_status_10bt_ops_regs.sv ***
// Testbench for the receive status and 10Base-T operations registers.
`timescale 1ns/1ps
module test_phy_rx_status_10bt_ops_regs;
	localparam int JC = 50;
	localparam logic [4:0] ST = phy_regs_pkg::ADDR_EVENT_STATUS;
	localparam logic [4:0] OPS = phy_regs_pkg::ADDR_TEN_BASE_T_OPS;
	localparam logic [4:0] DAT = 5'h1e;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [4:0]  addr;
	logic        rd;
	logic        wr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic        rvalid, rxer, lnk, jab, signal_quality_error_test, polc;
	logic        spd = 1'b1, dup = 1'b0, rep = 1'b0, an_en = 1'b0, an_done = 1'b0;
	logic        rflt = 1'b0, lnk100 = 1'b0, sym_vld = 1'b0, sigdet = 1'b0, pol = 1'b0;
	logic        tx = 1'b0, car = 1'b0, vdat = 1'b0, idl = 1'b0, lfail = 1'b0;
	logic [4:0]  sym_code = 5'h1f;
	logic [31:0] e;
	logic [19:0] d;
	logic [31:0] exp_q[$];
	int          err_count = 0;
	int          checks_done = 0;

	always #4 clk = ~clk;

	mgmt_station mgmt_u (.clk_in(clk), .addr_out(addr), .read_out(rd), .write_out(wr),
		.wdata_out(wdata));

	phy_rx_status_10bt_ops_regs #(.JABBER_CYCLES(JC)) dut_u (
		.CLK_SYS_IN(clk), .RESET_N_IN(rst_n), .MGMT_ADDR_IN(addr), .MGMT_READ_IN(rd),
		.MGMT_WRITE_IN(wr), .MGMT_WDATA_IN(wdata), .MGMT_RDATA_OUT(rdata),
		.MGMT_RVALID_OUT(rvalid), .SPEED_100_IN(spd), .FULL_DUPLEX_IN(dup),
		.REPEATER_MODE_IN(rep), .AN_ENABLE_IN(an_en), .AN_DONE_IN(an_done),
		.REMOTE_FAULT_IN(rflt), .LINK100_IN(lnk100), .RX_SYMBOL_IN(sym_code),
		.RX_SYMBOL_VALID_IN(sym_vld), .RXER_OUT(rxer), .PAIR_SIGNAL_DETECT_IN(sigdet),
		.PAIR_POLARITY_REVERSED_IN(pol), .TX_EN_IN(tx), .RX_CARRIER_IN(car),
		.RX10_VALID_DATA_IN(vdat), .RX10_IDLE_IN(idl), .LINK_PULSE_FAIL_IN(lfail),
		.LINK_PASS_OUT(lnk), .JABBER_OUT(jab), .SQE_TEST_OUT(signal_quality_error_test),
		.POLARITY_CORRECT_OUT(polc));

	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		checks_done++;
		if (seen !== want) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, seen, want);
		end
	endtask

	task automatic chkb(input logic seen, input logic want);
		check({15'h0000, seen}, {15'h0000, want});
	endtask

	task automatic rdx(input logic [4:0] a, input logic [15:0] v, input logic [15:0] m);
		exp_q.push_back({m, v & m});
		mgmt_u.rd(a);
	endtask

	task automatic sym(input logic [4:0] c, input logic bad);
		@(negedge clk);
		sym_code = c;
		sym_vld = 1'b1;
		@(negedge clk);
		sym_vld = 1'b0;
		sym_code = ~c;
		chkb(rxer, bad);
	endtask

	// A short spell in 10Base-T mode returns the symbol tracker to idle.
	task automatic to_idle();
		spd = 1'b0;
		sym(DAT, 1'b0);
		spd = 1'b1;
	endtask

	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
		repeat (3) @(negedge clk);
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic end_of_test();
		wait_n(4);
		$display("Checks made %0d, mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	always @(negedge clk) begin
		if (rst_n && rvalid) begin
			e = exp_q.pop_front();
			check(rdata & e[31:16], e[15:0]);
		end
	end

	initial begin
		#200us;
		err_count++;
		end_of_test();
	end

	initial begin
		void'($urandom(44));
		wait_n(20);
		rst_n = 1'b1;
		rdx(OPS, 16'h0010, 16'hffff);
		rdx(ST, 16'h0000, 16'h01ff);
		d = 20'($urandom);
		mgmt_u.wr(OPS, d[15:0]);
		rdx(OPS, {10'h000, d[5], 1'b1, d[3:0]}, 16'hffff);
		mgmt_u.wr({1'b0, d[19:16]}, 16'hffff);
		rdx({1'b0, d[19:16]}, 16'h0000, 16'hffff);
		rdx(OPS, {10'h000, d[5], 1'b1, d[3:0]}, 16'hffff);
		mgmt_u.wr(OPS, 16'h0010);
		$display("register access test done");
		sym(DAT, 1'b0);
		rdx(ST, 16'h0100, 16'h01e0);
		rdx(ST, 16'h0000, 16'h01e0);
		to_idle();
		sym(phy_regs_pkg::CODE_J, 1'b0);
		sym(phy_regs_pkg::CODE_K, 1'b0);
		sym(DAT, 1'b0);
		sym(5'h00, 1'b1);
		rdx(ST, 16'h0080, 16'h01e0);
		to_idle();
		sym(phy_regs_pkg::CODE_J, 1'b0);
		sym(phy_regs_pkg::CODE_K, 1'b0);
		sym(phy_regs_pkg::CODE_HALT, 1'b1);
		rdx(ST, 16'h0040, 16'h01e0);
		to_idle();
		sym(phy_regs_pkg::CODE_J, 1'b0);
		sym(phy_regs_pkg::CODE_K, 1'b0);
		sym(DAT, 1'b0);
		sym(phy_regs_pkg::CODE_IDLE, 1'b0);
		sym(phy_regs_pkg::CODE_IDLE, 1'b0);
		rdx(ST, 16'h0020, 16'h01e0);
		sym(phy_regs_pkg::CODE_J, 1'b0);
		sym(phy_regs_pkg::CODE_K, 1'b0);
		sym(phy_regs_pkg::CODE_T, 1'b0);
		sym(DAT, 1'b1);
		sym(phy_regs_pkg::CODE_J, 1'b0);
		sym(DAT, 1'b0);
		rdx(ST, 16'h0180, 16'h01e0);
		sym(phy_regs_pkg::CODE_J, 1'b0);
		sym(phy_regs_pkg::CODE_K, 1'b0);
		fork
			sym(phy_regs_pkg::CODE_HALT, 1'b1);
			rdx(ST, 16'h0000, 16'h01e0);
		join
		rdx(ST, 16'h0040, 16'h01e0);
		to_idle();
		$display("receive event test done");
		{an_en, an_done, sigdet, rflt, lnk100} = 5'h1f;
		wait_n(8);
		rdx(ST, 16'h001a, 16'h001a);
		rdx(ST, 16'h0019, 16'h001b);
		pulse(lnk100);
		lnk100 = 1'b1;
		rdx(ST, 16'h0000, 16'h0001);
		an_en = 1'b0;
		rdx(ST, 16'h0001, 16'h0011);
		spd = 1'b0;
		$display("status mirror test done");
		for (int i = 0; i < 4; i++) begin
			mgmt_u.wr(OPS, (i == 1) ? 16'h0014 : 16'h0010);
			dup = (i == 2);
			rep = (i == 3);
			tx = 1'b1;
			wait_n(10);
			tx = 1'b0;
			wait_n(3);
			chkb(signal_quality_error_test, i == 0);
			rdx(OPS, (i == 1) ? 16'h0014 : 16'h0010, 16'hffff);
			wait_n(130);
			chkb(signal_quality_error_test, 1'b0);
		end
		{dup, rep} = 2'b00;
		for (int i = 0; i < 2; i++) begin
			mgmt_u.wr(OPS, (i == 1) ? 16'h0030 : 16'h0010);
			tx = 1'b1;
			wait_n(JC + 8);
			chkb(jab, i == 0);
			tx = 1'b0;
			wait_n(3);
			chkb(jab, 1'b0);
			rdx(ST, (i == 0) ? 16'h0004 : 16'h0000, 16'h0004);
			wait_n(140);
		end
		mgmt_u.wr(OPS, 16'h0010);
		car = 1'b1;
		wait_n(JC + 8);
		chkb(jab, 1'b0);
		car = 1'b0;
		rdx(OPS, 16'h8010, 16'hffff);
		rdx(OPS, 16'h0010, 16'hffff);
		pol = 1'b1;
		wait_n(8);
		chkb(polc, 1'b1);
		rdx(OPS, 16'h4010, 16'hffff);
		mgmt_u.wr(OPS, 16'h0018);
		wait_n(3);
		chkb(polc, 1'b0);
		pol = 1'b0;
		$display("operations test done");
		for (int i = 0; i < 2; i++) begin
			mgmt_u.wr(OPS, (i == 1) ? 16'h0011 : 16'h0010);
			pulse(lfail);
			chkb(lnk, 1'b0);
			pulse(vdat);
			chkb(lnk, i == 0);
			pulse(idl);
			chkb(lnk, 1'b1);
		end
		mgmt_u.wr(OPS, 16'h0012);
		pulse(lfail);
		chkb(lnk, 1'b1);
		$display("link test done");
		end_of_test();
	end
endmodule

bind phy_rx_status_10bt_ops_regs phy_regs_checker #(.JABBER_CYCLES(JABBER_CYCLES)) chk_u (
	.CLK_SYS_IN, .RESET_N_IN, .MGMT_ADDR_IN, .MGMT_READ_IN, .MGMT_WRITE_IN, .MGMT_WDATA_IN,
	.MGMT_RDATA_OUT, .MGMT_RVALID_OUT, .SPEED_100_IN, .FULL_DUPLEX_IN, .REPEATER_MODE_IN,
	.AN_ENABLE_IN, .RX_SYMBOL_VALID_IN, .RXER_OUT, .TX_EN_IN, .LINK_PASS_OUT, .JABBER_OUT,
	.SQE_TEST_OUT, .POLARITY_CORRECT_OUT);
